// [src/scpb_pkg.sv]
// package of offsets, fields and reset values for the sensor channel parameter bank
package scpb_pkg;
  // parameter offsets
  localparam logic [7:0] OFF_BUS_ADDR = 8'h00;
  localparam logic [7:0] OFF_CHAN_LIST = 8'h01;
  localparam logic [7:0] OFF_EMIT_CH12 = 8'h02;
  localparam logic [7:0] OFF_EMIT_CH3 = 8'h03;
  localparam logic [7:0] OFF_ALIGN = 8'h05;
  localparam logic [7:0] OFF_ALS_HIST = 8'h19;
  localparam logic [7:0] OFF_ADC_OFFSET = 8'h1A;
  localparam logic [7:0] OFF_RSVD_1B = 8'h1B;
  localparam logic [7:0] OFF_EMIT_REC = 8'h1C;
  localparam logic [7:0] OFF_IR_COUNT = 8'h1D;
  localparam logic [7:0] OFF_IR_GAIN = 8'h1E;
  localparam logic [7:0] OFF_IR_RANGE = 8'h1F;
  // reset values
  localparam logic [7:0] RST_BUS_ADDR = 8'h00;
  localparam logic [7:0] RST_CHAN_LIST = 8'h00;
  localparam logic [7:0] RST_EMIT_CH12 = 8'h21;
  localparam logic [7:0] RST_EMIT_CH3 = 8'h04;
  localparam logic [7:0] RST_ALIGN = 8'h00;
  localparam logic [7:0] RST_RSVD_1B = 8'h00;
  localparam logic [7:0] RST_OTHER = 8'h00;
  localparam logic [6:0] RST_SLAVE_ADDR = 7'h10; // power-up slave address; the value is arbitrary
  // channel list bit positions
  localparam int BIT_PROX1 = 0;
  localparam int BIT_PROX2 = 1;
  localparam int BIT_PROX3 = 2;
  localparam int BIT_VIS = 4;
  localparam int BIT_IR = 5;
  localparam int BIT_AUX = 6;
  // emitter field low bits and alignment bit positions
  localparam int EMIT_P1_LSB = 0;
  localparam int EMIT_P2_LSB = 4;
  localparam int EMIT_P3_LSB = 0;
  localparam int ALIGN_P1 = 4;
  localparam int ALIGN_P2 = 5;
  localparam int ALIGN_P3 = 6;
  // channel indices of the measurement select
  localparam logic [2:0] CH_PROX1 = 3'h0;
  localparam logic [2:0] CH_PROX2 = 3'h1;
  localparam logic [2:0] CH_PROX3 = 3'h2;
  localparam logic [2:0] CH_VIS = 3'h4;
  localparam logic [2:0] CH_IR = 3'h5;
  localparam logic [2:0] CH_AUX = 3'h6;
  // whole state of the bank
  typedef struct packed {
    logic [7:0] address_change_command;
    logic [7:0] chanList;
    logic [7:0] emitCh12;
    logic [7:0] emitCh3;
    logic [7:0] align;
    logic [7:0] alsHist;
    logic [7:0] adcOffset;
    logic [7:0] rsvd1b;
    logic [7:0] emitRec;
    logic [7:0] irCount;
    logic [7:0] irGain;
    logic [7:0] irRange;
    logic [6:0] slaveAddr;
    logic [7:0] readData;
    logic [15:0] resProx1;
    logic [15:0] resProx2;
    logic [15:0] resProx3;
    logic [15:0] resVis;
    logic [15:0] resIr;
    logic [15:0] resAux;
  } scpb_state_t;
endpackage

// [src/scpb_bank.sv]
// parameter bank, emitter select, result alignment and result storage of the sensor
// Operation
// - new slave address applies only on command
// - bit 6 runs auxiliary channel, stores result
// - bit 5 runs ambient infrared channel
// - bit 4 runs ambient visible channel
// - bits 0..2 enable proximity channels 1..3
// - bits 2:0 pick proximity one emitters
// - bits 6:4 pick proximity two emitters
// - bits 2:0 pick proximity three emitters
// - first emitter select resets to 0x21
// - second emitter select resets to 0x04
// - bit 6 selects low bits, channel 3
// - bit 5 selects low bits, channel 2
// - bit 4 selects low bits, channel 1
// - parameters reached only by set/query commands
`timescale 1ns/1ps
`default_nettype none
module scpb_bank
  import scpb_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // parameter command port from the command sequencer
  input wire logic paramWrite,
  input wire logic paramRead,
  input wire logic [7:0] paramOffset,
  input wire logic [7:0] paramWrData,
  output logic [7:0] paramRdData,
  // address change command
  input wire logic addressChangeCommand,
  output logic [6:0] slaveAddress,
  // measurement sequencer
  input wire logic [2:0] measChannel,
  input wire logic measActive,
  input wire logic convDone,
  input wire logic [16:0] convResult,
  // channel enables
  output logic proximityOneEnable,
  output logic proximityTwoEnable,
  output logic proximityThreeEnable,
  output logic ambientVisibleEnable,
  output logic ambientInfraredEnable,
  output logic auxiliaryEnable,
  // emitter drive
  output logic emitterOutputOne,
  output logic emitterOutputTwo,
  output logic emitterOutputThree,
  // result bytes
  output logic [15:0] proxOneResult,
  output logic [15:0] proxTwoResult,
  output logic [15:0] proxThreeResult,
  output logic [15:0] ambientVisibleResult,
  output logic [15:0] ambientInfraredResult,
  output logic [7:0] auxiliaryResultLow,
  output logic [7:0] auxiliaryResultHigh,
  // converter settings out to the analogue side
  output logic [7:0] alsHistory,
  output logic [7:0] converterOffset,
  output logic [7:0] emitterRecovery,
  output logic [7:0] irConvTime,
  output logic [7:0] irGain,
  output logic [7:0] irRange
);

  // current and next state
  scpb_state_t st;
  scpb_state_t next_st;
  // emitters chosen for the channel now measured
  logic [2:0] emitSel;
  // aligned 16-bit result of the finished conversion
  logic [15:0] aligned;

  // pick 16 of 17 converter bits: low bits when set, upper bits when clear
  // the bit comes from the stored parameter, so a write in the same cycle
  // as a capture only affects the following capture
  function automatic logic [15:0] align16(input logic lowBits, input logic [16:0] raw);
    if (lowBits) begin
      align16 = raw[15:0];
    end else begin
      align16 = raw[16:1];
    end
  endfunction

  // emitters and alignment per proximity channel
  // only the three proximity channels carry an emitter choice
  always_comb begin
    emitSel = 3'h0;
    aligned = convResult[16:1];
    case (measChannel)
      CH_PROX1: begin
        emitSel = st.emitCh12[EMIT_P1_LSB +: 3];
        aligned = align16(st.align[ALIGN_P1], convResult);
      end
      CH_PROX2: begin
        emitSel = st.emitCh12[EMIT_P2_LSB +: 3];
        aligned = align16(st.align[ALIGN_P2], convResult);
      end
      CH_PROX3: begin
        emitSel = st.emitCh3[EMIT_P3_LSB +: 3];
        aligned = align16(st.align[ALIGN_P3], convResult);
      end
      default: begin
        emitSel = 3'h0;
        aligned = convResult[16:1];
      end
    endcase
  end

  // next state: parameter writes, reads, address switch, result capture
  always_comb begin
    next_st = st;
    // parameter set command; each location holds until rewritten
    // reserved bits are stored as written, the host keeps them at zero
    if (paramWrite) begin
      if (paramOffset == OFF_BUS_ADDR) begin
        // staged only; the bus keeps answering at the active address
        next_st.address_change_command = paramWrData;
      end else if (paramOffset == OFF_CHAN_LIST) begin
        // enables apply from the next conversion on
        next_st.chanList = paramWrData;
      end else if (paramOffset == OFF_EMIT_CH12) begin
        // emitter choice of proximity channels one and two
        next_st.emitCh12 = paramWrData;
      end else if (paramOffset == OFF_EMIT_CH3) begin
        // emitter choice of proximity channel three
        next_st.emitCh3 = paramWrData;
      end else if (paramOffset == OFF_ALIGN) begin
        // alignment bits, used by the next proximity capture
        next_st.align = paramWrData;
      end else if (paramOffset == OFF_ALS_HIST) begin
        // ambient filter history setting
        next_st.alsHist = paramWrData;
      end else if (paramOffset == OFF_ADC_OFFSET) begin
        // converter offset setting
        next_st.adcOffset = paramWrData;
      end else if (paramOffset == OFF_RSVD_1B) begin
        // reserved location, kept as plain storage
        next_st.rsvd1b = paramWrData;
      end else if (paramOffset == OFF_EMIT_REC) begin
        // emitter recovery time
        next_st.emitRec = paramWrData;
      end else if (paramOffset == OFF_IR_COUNT) begin
        // infrared conversion time
        next_st.irCount = paramWrData;
      end else if (paramOffset == OFF_IR_GAIN) begin
        // infrared converter gain
        next_st.irGain = paramWrData;
      end else if (paramOffset == OFF_IR_RANGE) begin
        // infrared converter range
        next_st.irRange = paramWrData;
      end
    end
    // parameter query command; unmapped offsets read zero
    // the holding register keeps its value until the next query
    if (paramRead) begin
      if (paramOffset == OFF_BUS_ADDR) begin
        next_st.readData = st.address_change_command;
      end else if (paramOffset == OFF_CHAN_LIST) begin
        next_st.readData = st.chanList;
      end else if (paramOffset == OFF_EMIT_CH12) begin
        next_st.readData = st.emitCh12;
      end else if (paramOffset == OFF_EMIT_CH3) begin
        next_st.readData = st.emitCh3;
      end else if (paramOffset == OFF_ALIGN) begin
        next_st.readData = st.align;
      end else if (paramOffset == OFF_ALS_HIST) begin
        next_st.readData = st.alsHist;
      end else if (paramOffset == OFF_ADC_OFFSET) begin
        next_st.readData = st.adcOffset;
      end else if (paramOffset == OFF_RSVD_1B) begin
        next_st.readData = st.rsvd1b;
      end else if (paramOffset == OFF_EMIT_REC) begin
        next_st.readData = st.emitRec;
      end else if (paramOffset == OFF_IR_COUNT) begin
        next_st.readData = st.irCount;
      end else if (paramOffset == OFF_IR_GAIN) begin
        next_st.readData = st.irGain;
      end else if (paramOffset == OFF_IR_RANGE) begin
        next_st.readData = st.irRange;
      end else begin
        next_st.readData = 8'h00;
      end
    end
    // slave address moves only on the address change command
    // a command in the same cycle as the address write takes the old value
    if (addressChangeCommand) begin
      next_st.slaveAddr = st.address_change_command[6:0];
    end
    // store a finished conversion into the enabled channel's result bytes
    // a disabled channel or an unused index leaves every result alone
    if (convDone) begin
      case (measChannel)
        CH_PROX1: begin
          if (st.chanList[BIT_PROX1]) begin
            next_st.resProx1 = aligned;
          end
        end
        CH_PROX2: begin
          if (st.chanList[BIT_PROX2]) begin
            next_st.resProx2 = aligned;
          end
        end
        CH_PROX3: begin
          if (st.chanList[BIT_PROX3]) begin
            next_st.resProx3 = aligned;
          end
        end
        // ambient and auxiliary results always keep the upper 16 bits
        CH_VIS: begin
          if (st.chanList[BIT_VIS]) begin
            next_st.resVis = convResult[16:1];
          end
        end
        CH_IR: begin
          if (st.chanList[BIT_IR]) begin
            next_st.resIr = convResult[16:1];
          end
        end
        CH_AUX: begin
          if (st.chanList[BIT_AUX]) begin
            next_st.resAux = convResult[16:1];
          end
        end
        default: begin
          // indices 3 and 7 store nothing
          next_st.resAux = st.resAux;
        end
      endcase
    end
  end

  // state register with documented defaults
  // the reset branch loads constants only
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      // parameter defaults
      st.address_change_command <= RST_BUS_ADDR;
      st.chanList <= RST_CHAN_LIST;
      st.emitCh12 <= RST_EMIT_CH12;
      st.emitCh3 <= RST_EMIT_CH3;
      st.align <= RST_ALIGN;
      st.alsHist <= RST_OTHER;
      st.adcOffset <= RST_OTHER;
      st.rsvd1b <= RST_RSVD_1B;
      st.emitRec <= RST_OTHER;
      st.irCount <= RST_OTHER;
      st.irGain <= RST_OTHER;
      st.irRange <= RST_OTHER;
      // active address and read holding register
      st.slaveAddr <= RST_SLAVE_ADDR;
      st.readData <= 8'h00;
      // result bytes
      st.resProx1 <= 16'h0000;
      st.resProx2 <= 16'h0000;
      st.resProx3 <= 16'h0000;
      st.resVis <= 16'h0000;
      st.resIr <= 16'h0000;
      st.resAux <= 16'h0000;
    end else begin
      st <= next_st;
    end
  end

  // outputs
  assign paramRdData = st.readData;
  assign slaveAddress = st.slaveAddr;
  // channel enables straight from the stored list
  assign proximityOneEnable = st.chanList[BIT_PROX1];
  assign proximityTwoEnable = st.chanList[BIT_PROX2];
  assign proximityThreeEnable = st.chanList[BIT_PROX3];
  assign ambientVisibleEnable = st.chanList[BIT_VIS];
  assign ambientInfraredEnable = st.chanList[BIT_IR];
  assign auxiliaryEnable = st.chanList[BIT_AUX];
  // emitters pulse only while a proximity measurement runs
  assign emitterOutputOne = measActive & emitSel[0];
  assign emitterOutputTwo = measActive & emitSel[1];
  assign emitterOutputThree = measActive & emitSel[2];
  // result bytes from their holding registers
  assign proxOneResult = st.resProx1;
  assign proxTwoResult = st.resProx2;
  assign proxThreeResult = st.resProx3;
  assign ambientVisibleResult = st.resVis;
  assign ambientInfraredResult = st.resIr;
  assign auxiliaryResultLow = st.resAux[7:0];
  assign auxiliaryResultHigh = st.resAux[15:8];
  // converter settings to the analogue side
  assign alsHistory = st.alsHist;
  assign converterOffset = st.adcOffset;
  assign emitterRecovery = st.emitRec;
  assign irConvTime = st.irCount;
  assign irGain = st.irGain;
  assign irRange = st.irRange;

endmodule
`default_nettype wire

// [sim/scpb_bank_assertions.sv]
// port checker of the parameter bank
`timescale 1ns/1ps
`default_nettype none
module scpb_bank_checker (
  // clock, reset
  input wire logic mclk,
  input wire logic rst_n,
  // command side
  input wire logic paramWrite,
  input wire logic paramRead,
  input wire logic [7:0] paramOffset,
  input wire logic [7:0] paramWrData,
  input wire logic [7:0] paramRdData,
  input wire logic addressChangeCommand,
  input wire logic [6:0] slaveAddress,
  // measurement side
  input wire logic [2:0] measChannel,
  input wire logic measActive,
  input wire logic convDone,
  input wire logic [16:0] convResult,
  input wire logic proximityOneEnable,
  input wire logic ambientInfraredEnable,
  input wire logic auxiliaryEnable,
  input wire logic emitterOutputOne,
  input wire logic emitterOutputTwo,
  input wire logic emitterOutputThree,
  input wire logic [15:0] proxOneResult,
  input wire logic [15:0] ambientInfraredResult,
  input wire logic [7:0] auxiliaryResultLow,
  input wire logic [7:0] auxiliaryResultHigh,
  input wire logic [7:0] irGain
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // alignment bit of proximity channel one, tracked from parameter writes
  logic p1Low;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      p1Low <= 1'b0;
    end else if (paramWrite && paramOffset == 8'h05) begin
      p1Low <= paramWrData[4];
    end
  end
  // write to the channel list
  sequence s_list;
    paramWrite && paramOffset == 8'h01;
  endsequence
  // capture on an enabled aux channel
  sequence s_aux;
    convDone && measChannel == 3'h6 && auxiliaryEnable;
  endsequence
  property p_addr; !addressChangeCommand |=> $stable(slaveAddress); endproperty
  a_addr: assert property (p_addr) else $error("slave address moved");
  property p_aux; s_list |=> auxiliaryEnable == $past(paramWrData[6]); endproperty
  a_aux: assert property (p_aux) else $error("aux enable wrong");
  property p_ir; s_list |=> ambientInfraredEnable == $past(paramWrData[5]); endproperty
  a_ir: assert property (p_ir) else $error("ir enable wrong");
  property p_p1; s_list |=> proximityOneEnable == $past(paramWrData[0]); endproperty
  a_p1: assert property (p_p1) else $error("prox enable wrong");
  property p_idle; !measActive |-> !(emitterOutputOne || emitterOutputTwo || emitterOutputThree); endproperty
  a_idle: assert property (p_idle) else $error("emitter idle drive");
  property p_np; measChannel > 3'h2 |-> !(emitterOutputOne || emitterOutputTwo || emitterOutputThree); endproperty
  a_np: assert property (p_np) else $error("emitter on non-prox");
  property p_auxc; s_aux |=> {auxiliaryResultHigh, auxiliaryResultLow} == $past(convResult[16:1]); endproperty
  a_auxc: assert property (p_auxc) else $error("aux result wrong");
  property p_irs; convDone && measChannel == 3'h5 && !ambientInfraredEnable |=> $stable(ambientInfraredResult);
  endproperty
  a_irs: assert property (p_irs) else $error("disabled ir captured");
  property p_p1c; convDone && measChannel == 3'h0 && proximityOneEnable |=>
    proxOneResult == ($past(p1Low) ? $past(convResult[15:0]) : $past(convResult[16:1])); endproperty
  a_p1c: assert property (p_p1c) else $error("prox result wrong");
  property p_hold; !paramWrite |=> $stable(irGain); endproperty
  a_hold: assert property (p_hold) else $error("parameter moved");
  property p_rd; !paramRead |=> $stable(paramRdData); endproperty
  a_rd: assert property (p_rd) else $error("read data moved");
endmodule
`default_nettype wire

// [sim/scpb_host.sv]
// host model issuing parameter set, query and address commands
`timescale 1ns/1ps
`default_nettype none
module scpb_host (
  // clock
  input wire logic mclk,
  // command port
  output logic paramWrite,
  output logic paramRead,
  output logic [7:0] paramOffset,
  output logic [7:0] paramWrData,
  output logic addressChangeCommand,
  // read data back
  input wire logic [7:0] paramRdData
);
  // idle at time zero
  initial begin
    paramWrite = 1'b0;
    paramRead = 1'b0;
    paramOffset = 8'h00;
    paramWrData = 8'h00;
    addressChangeCommand = 1'b0;
  end
  // set: one-cycle pulse, data scrambled once released
  task automatic wr(input logic [7:0] off, input logic [7:0] d);
    @(negedge mclk);
    paramOffset = off;
    paramWrData = d;
    paramWrite = 1'b1;
    @(negedge mclk);
    paramWrite = 1'b0;
    paramWrData = ~d;
  endtask
  // query: data taken one cycle on
  task automatic rd(input logic [7:0] off, output logic [7:0] d);
    @(negedge mclk);
    paramOffset = off;
    paramRead = 1'b1;
    @(negedge mclk);
    paramRead = 1'b0;
    d = paramRdData;
  endtask
  // address change pulse
  task automatic cmd();
    @(negedge mclk);
    addressChangeCommand = 1'b1;
    @(negedge mclk);
    addressChangeCommand = 1'b0;
  endtask
endmodule
`default_nettype wire

// [sim/tb_scpb_bank.sv]
// self-checking bench of the parameter bank
`timescale 1ns/1ps
`default_nettype none
module tb_scpb_bank;
  import scpb_pkg::*;
  logic mclk = 1'b0, rst_n = 1'b0, measActive = 1'b0, convDone = 1'b0;
  logic [2:0] measChannel = 3'h0;
  logic [16:0] convResult = 17'h00000;
  logic paramWrite, paramRead, addressChangeCommand;
  logic [7:0] paramOffset, paramWrData, paramRdData, rdv, auxiliaryResultLow, auxiliaryResultHigh;
  logic [6:0] slaveAddress;
  logic proximityOneEnable, proximityTwoEnable, proximityThreeEnable;
  logic ambientVisibleEnable, ambientInfraredEnable, auxiliaryEnable;
  logic emitterOutputOne, emitterOutputTwo, emitterOutputThree;
  logic [15:0] proxOneResult, proxTwoResult, proxThreeResult, ambientVisibleResult, ambientInfraredResult;
  logic [7:0] alsHistory, converterOffset, emitterRecovery, irConvTime, irGain, irRange;
  logic [7:0] offs [7] = '{OFF_BUS_ADDR, OFF_ALS_HIST, OFF_ADC_OFFSET, OFF_EMIT_REC, OFF_IR_COUNT, OFF_IR_GAIN,
    OFF_IR_RANGE};
  logic [7:0] vals [7] = '{8'h3C, 8'h11, 8'h22, 8'h33, 8'h70, 8'h05, 8'h20};
  int badCount = 0, checkCount = 0;
  scpb_bank scpb_bank_inst (.mclk, .rst_n, .paramWrite, .paramRead, .paramOffset, .paramWrData, .paramRdData,
    .addressChangeCommand, .slaveAddress, .measChannel, .measActive, .convDone, .convResult,
    .proximityOneEnable, .proximityTwoEnable, .proximityThreeEnable, .ambientVisibleEnable,
    .ambientInfraredEnable, .auxiliaryEnable, .emitterOutputOne, .emitterOutputTwo, .emitterOutputThree,
    .proxOneResult, .proxTwoResult, .proxThreeResult, .ambientVisibleResult, .ambientInfraredResult,
    .auxiliaryResultLow, .auxiliaryResultHigh, .alsHistory, .converterOffset, .emitterRecovery,
    .irConvTime, .irGain, .irRange);
  scpb_host scpb_host_inst (.mclk, .paramWrite, .paramRead, .paramOffset, .paramWrData,
    .addressChangeCommand, .paramRdData);
  // clock
  always #5 mclk = ~mclk;
  // compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checkCount++;
    if (got !== exp) begin
      badCount++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // query a parameter and compare
  task automatic rc(input logic [7:0] off, input logic [7:0] exp);
    scpb_host_inst.rd(off, rdv);
    chk({8'h00, rdv}, {8'h00, exp});
  endtask
  // one converter capture
  task automatic cap(input logic [2:0] ch, input logic [16:0] v);
    @(negedge mclk);
    measChannel = ch;
    convResult = v;
    convDone = 1'b1;
    @(negedge mclk);
    convDone = 1'b0;
    convResult = ~v;
  endtask
  // emitters seen during one channel
  task automatic em(input logic [2:0] ch, input logic [2:0] exp);
    @(negedge mclk);
    measChannel = ch;
    measActive = 1'b1;
    @(negedge mclk);
    chk({13'h0, emitterOutputThree, emitterOutputTwo, emitterOutputOne}, {13'h0, exp});
    measActive = 1'b0;
  endtask
  // verdict
  task automatic results();
    $display("checks=%0d mismatches=%0d", checkCount, badCount);
    if (badCount == 0 && checkCount > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // hang guard
  initial begin
    #200000;
    badCount++;
    results();
  end
  // main sequence
  initial begin
    repeat (3) @(posedge mclk);
    @(negedge mclk) rst_n = 1'b1;
    rc(OFF_EMIT_CH12, 8'h21);
    rc(OFF_EMIT_CH3, 8'h04);
    rc(OFF_CHAN_LIST, 8'h00);
    rc(OFF_RSVD_1B, 8'h00);
    chk({9'h0, slaveAddress}, {9'h0, RST_SLAVE_ADDR});
    $display("test reset done");
    foreach (offs[i]) scpb_host_inst.wr(offs[i], vals[i]);
    foreach (offs[i]) rc(offs[i], vals[i]);
    chk({alsHistory, converterOffset}, 16'h1122);
    chk({emitterRecovery, irConvTime}, 16'h3370);
    chk({irGain, irRange}, 16'h0520);
    scpb_host_inst.wr(8'h20, 8'hFF);
    rc(8'h20, 8'h00);
    $display("test storage done");
    scpb_host_inst.wr(OFF_BUS_ADDR, 8'h39);
    chk({9'h0, slaveAddress}, {9'h0, RST_SLAVE_ADDR});
    scpb_host_inst.cmd();
    chk({9'h0, slaveAddress}, 16'h0039);
    $display("test address done");
    scpb_host_inst.wr(OFF_CHAN_LIST, 8'h77);
    chk({9'h0, auxiliaryEnable, ambientInfraredEnable, ambientVisibleEnable, 1'b0, proximityThreeEnable,
      proximityTwoEnable, proximityOneEnable}, 16'h0077);
    for (int a = 0; a < 2; a++) begin
      scpb_host_inst.wr(OFF_ALIGN, a ? 8'h20 : 8'h50);
      cap(3'h0, 17'h1ABCD);
      cap(3'h1, 17'h0F0F1);
      cap(3'h2, 17'h13579);
      chk(proxOneResult, a ? 16'hD5E6 : 16'hABCD);
      chk(proxTwoResult, a ? 16'hF0F1 : 16'h7878);
      chk(proxThreeResult, a ? 16'h9ABC : 16'h3579);
    end
    cap(3'h4, 17'h12345);
    chk(ambientVisibleResult, 16'h91A2);
    cap(3'h5, 17'h0ACE1);
    chk(ambientInfraredResult, 16'h5670);
    cap(3'h6, 17'h1F00F);
    chk({auxiliaryResultHigh, auxiliaryResultLow}, 16'hF807);
    scpb_host_inst.wr(OFF_CHAN_LIST, 8'h01);
    cap(3'h5, 17'h00000);
    chk(ambientInfraredResult, 16'h5670);
    cap(3'h2, 17'h00000);
    chk(proxThreeResult, 16'h9ABC);
    $display("test channels done");
    scpb_host_inst.wr(OFF_EMIT_CH12, 8'h53);
    scpb_host_inst.wr(OFF_EMIT_CH3, 8'h06);
    em(3'h0, 3'h3);
    em(3'h1, 3'h5);
    em(3'h2, 3'h6);
    em(3'h4, 3'h0);
    $display("test emitters done");
    @(negedge mclk) rst_n = 1'b0;
    @(negedge mclk) rst_n = 1'b1;
    rc(OFF_EMIT_CH12, 8'h21);
    chk({9'h0, slaveAddress}, {9'h0, RST_SLAVE_ADDR});
    $display("test second reset done");
    results();
  end
endmodule
bind scpb_bank scpb_bank_checker scpb_bank_checker_inst (.mclk, .rst_n, .paramWrite, .paramRead, .paramOffset,
  .paramWrData, .paramRdData, .addressChangeCommand, .slaveAddress, .measChannel, .measActive, .convDone,
  .convResult, .proximityOneEnable, .ambientInfraredEnable, .auxiliaryEnable, .emitterOutputOne,
  .emitterOutputTwo, .emitterOutputThree, .proxOneResult, .ambientInfraredResult, .auxiliaryResultLow,
  .auxiliaryResultHigh, .irGain);
`default_nettype wire
